// ---- adc_link_end.sv ----
// Converter end: sample pipeline, fast detect, wake-up timing and lane start-up sequence.
`timescale 1ns/10ps
module adc_link_end
  import link_pkg::*;
#(
  parameter int WAKE_ADC = WAKE_ADC_CYC,
  parameter int WAKE_OUT = WAKE_OUT_CYC,
  parameter int LAT_LANE = LAT_LANE_CYC,
  parameter int LAT_FD   = LAT_FD_CYC
) (
  input  wire logic                clk_sys,    // Divided conversion clock.
  input  wire logic                rstn,
  input  wire logic                subclass1,
  input  wire logic                adcPowerDown,
  input  wire logic                outPowerDown,
  input  wire logic [SAMPLE_W-1:0] sampleIn,
  input  wire logic                overrangeIn,
  input  wire logic                sdioReadActive,
  input  wire logic                sdioBit,
  link_if.dev                      lnk,
  output logic                     overrange_threshold_flag,
  output logic                     dataReady,
  output logic                     code_group_sync_phase
);
  initial begin
    if (LAT_LANE < 2 || LAT_FD < 2 || WAKE_ADC < 1 || WAKE_OUT < 1) $error("bad parameter");
  end
  localparam int SC0_CYC = SC0_DELAY_MF * FRAMES_PER_MF;
  localparam int SC1_CYC = SC1_DELAY_MF * FRAMES_PER_MF;
  localparam int CGS_CYC = CGS_MIN_MF * FRAMES_PER_MF;

  typedef enum logic [4:0] {
    S_OFF = 5'h01, S_WAIT = 5'h02, S_CGS = 5'h04, S_ILA = 5'h08, S_DATA = 5'h10
  } lstate_t;
  lstate_t     state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [4:0]  frame_q;
  logic [31:0] wakeAdc_q, wakeOut_q;
  logic [SAMPLE_W-1:0] pipe_q [LAT_LANE];
  logic [LAT_FD-1:0]   fdPipe_q;
  logic [1:0]  ovrHold_q;
  logic        sync1_q, sync2_q, syncOld_q, sys1_q, sys2_q, sysOld_q;
  logic        rdSync1_q, rdSync2_q;
  logic        half_q;
  logic [9:0]  word_q;
  wire         syncFall  = syncOld_q & ~sync2_q;
  wire         syncRise  = ~syncOld_q & sync2_q;
  wire         sysRise   = ~sysOld_q & sys2_q;
  wire         mfEdge    = (frame_q == 5'h1F);
  wire         laneAwake = (wakeOut_q >= 32'(WAKE_OUT));
  wire [19:0]  lineBits  = {3'h0, pipe_q[LAT_LANE-1], 3'h0};

  // Pin inputs pass two flops; sysref is captured on the rising sample-clock edge.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_q   <= 1'b1;
      sync2_q   <= 1'b1;
      syncOld_q <= 1'b1;
      sys1_q    <= 1'b0;
      sys2_q    <= 1'b0;
      sysOld_q  <= 1'b0;
      rdSync1_q <= 1'b0;
      rdSync2_q <= 1'b0;
    end else begin
      sync1_q   <= lnk.syncReqN;
      sync2_q   <= sync1_q;
      syncOld_q <= sync2_q;
      sys1_q    <= lnk.sysrefIn;
      sys2_q    <= sys1_q;
      sysOld_q  <= sys2_q;
      rdSync1_q <= sdioReadActive;
      rdSync2_q <= rdSync1_q;
    end
  end

  // Wake-up counters restart whenever their power-down is held.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wakeAdc_q <= 32'h0;
      wakeOut_q <= 32'h0;
    end else begin
      if (adcPowerDown) wakeAdc_q <= 32'h0;
      else if (wakeAdc_q < 32'(WAKE_ADC)) wakeAdc_q <= wakeAdc_q + 32'h1;
      if (outPowerDown) wakeOut_q <= 32'h0;
      else if (wakeOut_q < 32'(WAKE_OUT)) wakeOut_q <= wakeOut_q + 32'h1;
    end
  end
  assign dataReady = (wakeAdc_q >= 32'(WAKE_ADC));

  // Sample pipeline and fast-detect; the overrange recovery hold counts down but drives no output.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < LAT_LANE; i++) pipe_q[i] <= '0;
      fdPipe_q  <= '0;
      ovrHold_q <= 2'h0;
      overrange_threshold_flag <= 1'b0;
    end else begin
      pipe_q[0] <= dataReady ? sampleIn : '0;
      for (int i = 1; i < LAT_LANE; i++) pipe_q[i] <= pipe_q[i-1];
      fdPipe_q <= {fdPipe_q[LAT_FD-2:0], overrangeIn};
      overrange_threshold_flag <= fdPipe_q[LAT_FD-2];
      if (overrangeIn) ovrHold_q <= 2'(OVR_RECOVER_CYC);
      else if (ovrHold_q != 2'h0) ovrHold_q <= ovrHold_q - 2'h1;
    end
  end

  // Lane start-up sequence.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 16'h1;
    unique case (state_q)
      S_OFF: begin
        cnt_d = 16'h0;
        if (laneAwake && (subclass1 ? sysRise : syncFall)) state_d = S_WAIT;
      end
      S_WAIT: if (cnt_q >= 16'((subclass1 ? SC1_CYC : SC0_CYC) - 1) && mfEdge) begin
        state_d = S_CGS;
        cnt_d   = 16'h0;
      end
      S_CGS: if (cnt_q >= 16'(CGS_CYC - 1) && sync2_q && mfEdge) begin
        state_d = S_ILA;
        cnt_d   = 16'h0;
      end
      S_ILA: if (mfEdge) state_d = S_DATA;
      S_DATA: if (!sync2_q) begin
        state_d = S_OFF;
      end
    endcase
    if (!laneAwake) state_d = S_OFF;
  end

  // Frame counter, state and two-half line serialiser (twenty bits per sample).
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_OFF;
      cnt_q   <= 16'h0;
      frame_q <= 5'h0;
      half_q  <= 1'b0;
      word_q  <= 10'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      frame_q <= frame_q + 5'h1;
      half_q  <= ~half_q;
      // The word follows the next state, so the word and its flags change on the same edge.
      unique case (state_d)
        S_CGS:   word_q <= K28_CHAR;
        S_ILA:   word_q <= ILA_CHAR;
        S_DATA:  word_q <= half_q ? lineBits[9:0] : lineBits[19:10];
        default: word_q <= 10'h0;
      endcase
    end
  end
  assign lnk.laneWord  = word_q;
  assign lnk.laneValid = laneAwake & (state_q != S_OFF) & (state_q != S_WAIT);
  assign lnk.laneIsK28 = (state_q == S_CGS);
  assign lnk.laneIsIla = (state_q == S_ILA);
  assign code_group_sync_phase = (state_q == S_CGS);

  // Serial data pin: drive only during a read (enable low when driving).
  // The read request passes two flops, which also leaves the host a cycle to let go first.
  assign lnk.sdioDev    = sdioBit;
  assign lnk.sdioDevOen = ~rdSync2_q;
  wire unusedSyncRise   = syncRise ^ lnk.sdioHost ^ lnk.sdioHostOen ^ (|ovrHold_q);
endmodule // adc_link_end

// ---- link_pkg.sv ----
// Package of constants shared by the converter link end and the receiver end.
package link_pkg;
  // Conversion clock (after the integer divider) in this model runs at clk_sys rate.
  localparam int CLK_MHZ          = 20;
  localparam int BITS_PER_SAMPLE  = 20;
  localparam int SAMPLE_W         = 14;
  localparam int FRAMES_PER_MF    = 32;
  localparam int SC0_DELAY_MF     = 5;
  localparam int SC1_DELAY_MF     = 6;
  localparam int CGS_MIN_MF       = 1;
  localparam int LAT_LANE_CYC     = 36;
  localparam int LAT_FD_CYC       = 7;
  localparam int OVR_RECOVER_CYC  = 3;
  localparam int WAKE_ADC_US      = 250;
  localparam int WAKE_OUT_US      = 50;
  localparam int SPI_RST_US       = 500;
  localparam int SDIO_TURN_NS     = 10;
  localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
  localparam int WAKE_ADC_CYC     = WAKE_ADC_US * CLK_MHZ;
  localparam int WAKE_OUT_CYC     = WAKE_OUT_US * CLK_MHZ;
  localparam int SPI_RST_CYC      = SPI_RST_US * CLK_MHZ;
  localparam int SDIO_TURN_CYC    = (SDIO_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] K28_CHAR = 10'h17C;
  localparam logic [9:0] ILA_CHAR = 10'h0F3;
endpackage

// ---- link_if.sv ----
// Interface joining the converter link end and the receiver end.
`timescale 1ns/10ps
interface link_if;
  logic       syncReqN;   // Receiver sync request, active low.
  logic       sysrefIn;   // System reference, launched on clk_sys.
  logic [9:0] laneWord;   // Half of a sample's line bits (20 bits sent as two words).
  logic       laneValid;
  logic       laneIsK28;
  logic       laneIsIla;
  logic       sdioHost;
  logic       sdioHostOen;
  logic       sdioDev;
  logic       sdioDevOen;
  modport dev  (input syncReqN, input sysrefIn, input sdioHost, input sdioHostOen,
                output laneWord, output laneValid, output laneIsK28, output laneIsIla,
                output sdioDev, output sdioDevOen);
  modport host (output syncReqN, output sysrefIn, output sdioHost, output sdioHostOen,
                input laneWord, input laneValid, input laneIsK28, input laneIsIla,
                input sdioDev, input sdioDevOen);
endinterface // link_if

// ---- link_rx_end.sv ----
// Receiver and serial-control host end of the converter link.
`timescale 1ns/10ps
module link_rx_end
  import link_pkg::*;
#(
  parameter int SPI_WAIT = SPI_RST_CYC,
  parameter int DELAY_MF = SC0_DELAY_MF
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic subclass1,
  input  wire logic linkStart,
  input  wire logic sdioRead,
  link_if.host      lnk,
  output logic      spiReady,
  output logic      cgsSearch,
  output logic      linkUp
);
  initial begin
    if (SPI_WAIT < 1 || DELAY_MF < SC0_DELAY_MF) $error("bad parameter");
  end
  localparam int DLY_CYC = DELAY_MF * FRAMES_PER_MF;
  localparam int CGS_CYC = CGS_MIN_MF * FRAMES_PER_MF;

  typedef enum logic [3:0] {
    R_IDLE = 4'h1, R_WAIT = 4'h2, R_CGS = 4'h4, R_DATA = 4'h8
  } rstate_t;
  rstate_t     state_q, state_d;
  logic [31:0] spiCnt_q;
  logic [15:0] cnt_q, cnt_d;
  logic        sysrefPulse;

  // Host holds off the serial port after reset.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) spiCnt_q <= 32'h0;
    else if (spiCnt_q < 32'(SPI_WAIT)) spiCnt_q <= spiCnt_q + 32'h1;
  end
  assign spiReady = (spiCnt_q >= 32'(SPI_WAIT));

  // Host drives the data pin only outside a read; released during the turnaround.
  assign lnk.sdioHost    = 1'b0;
  // The host takes the pin back only once the device has released it, so they never overlap.
  assign lnk.sdioHostOen = ~(spiReady & ~sdioRead & lnk.sdioDevOen);

  // Sysref is launched from a flop on clk_sys so the converter samples it cleanly.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) lnk.sysrefIn <= 1'b0;
    else lnk.sysrefIn <= sysrefPulse;
  end
  assign sysrefPulse = (state_q == R_IDLE) & linkStart & subclass1 & ~lnk.sysrefIn;

  // Link bring-up: request sync, wait the minimum delay, then search for K.28.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      R_IDLE: if (linkStart & ~lnk.sysrefIn) begin
        state_d = R_WAIT;
        cnt_d   = 16'h0;
      end
      R_WAIT: begin
        cnt_d = cnt_q + 16'h1;
        if (cnt_q >= 16'(DLY_CYC + (subclass1 ? FRAMES_PER_MF : 0))) begin
          state_d = R_CGS;
          cnt_d   = 16'h0;
        end
      end
      R_CGS: begin
        if (lnk.laneValid & lnk.laneIsK28) cnt_d = cnt_q + 16'h1;
        if (cnt_q >= 16'(CGS_CYC)) state_d = R_DATA;
      end
      R_DATA: if (!linkStart) state_d = R_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= R_IDLE;
      cnt_q   <= 16'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign lnk.syncReqN = ~(state_q == R_WAIT || state_q == R_CGS);
  assign cgsSearch    = (state_q == R_CGS);
  assign linkUp       = (state_q == R_DATA);
endmodule // link_rx_end

// ---- link_sva.sv ----
// Checker of the link start-up order and of data pin sharing on the link interface.
`timescale 1ns/10ps
module link_sva
  import link_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       syncReqN,
  input wire logic       sysrefIn,
  input wire logic [9:0] laneWord,
  input wire logic       laneValid,
  input wire logic       laneIsK28,
  input wire logic       laneIsIla,
  input wire logic       sdioHost,
  input wire logic       sdioHostOen,
  input wire logic       sdioDev,
  input wire logic       sdioDevOen
);
  localparam logic [15:0] SC0_MIN = 16'(SC0_DELAY_MF * FRAMES_PER_MF);
  localparam logic [15:0] SC1_MIN = 16'(SC1_DELAY_MF * FRAMES_PER_MF);
  localparam logic [15:0] CGS_MIN = 16'(CGS_MIN_MF * FRAMES_PER_MF);
  logic [15:0] syncCnt_q;
  logic [15:0] refCnt_q;
  logic [15:0] k28Cnt_q;
  // Cycles since the sync fall, since the last sysref and of the current K.28 run.
  // They saturate, so a long idle spell never wraps round into a false pass.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncCnt_q <= 16'h0;
      refCnt_q  <= 16'h0;
      k28Cnt_q  <= 16'h0;
    end else begin
      syncCnt_q <= syncReqN ? 16'h0 : syncCnt_q + {15'h0, ~&syncCnt_q};
      refCnt_q  <= sysrefIn ? 16'h1 : refCnt_q + {15'h0, (|refCnt_q) & ~&refCnt_q};
      k28Cnt_q  <= laneIsK28 ? k28Cnt_q + {15'h0, ~&k28Cnt_q} : 16'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Start-up order of the lane.
  AST_CGS_DELAY: assert property ($rose(laneIsK28) |-> syncCnt_q >= SC0_MIN || refCnt_q >= SC1_MIN)
    else $error("K28 began too soon after the trigger");
  AST_K28_NEEDS_SYNC: assert property ($rose(laneIsK28) |-> !syncReqN)
    else $error("K28 began with no sync request");
  AST_K28_MIN: assert property ($fell(laneIsK28) |-> k28Cnt_q >= CGS_MIN)
    else $error("K28 run shorter than one multiframe");
  AST_ILA_AFTER_K28: assert property ($rose(laneIsIla) |-> $past(laneIsK28))
    else $error("Alignment sequence not preceded by K28");
  AST_ILA_SOON: assert property ($rose(syncReqN) && laneIsK28 |-> ##[1:70] laneIsIla)
    else $error("Alignment sequence missing after sync release");
  AST_DATA_AFTER_ILA: assert property ($fell(laneIsIla) |-> laneValid && !laneIsK28)
    else $error("No sample data after the alignment sequence");
  // The data pin is shared, so only one end may drive it, with a gap before the device takes it.
  AST_SDIO_ONE: assert property (sdioDevOen || sdioHostOen)
    else $error("Both ends drive the data pin");
  AST_SDIO_TURN: assert property ($fell(sdioDevOen) |-> $past(sdioHostOen))
    else $error("Device drove the data pin with no turnaround gap");
  COV_K28: cover property ($rose(laneIsK28));
  COV_ILA: cover property ($rose(laneIsIla));
  COV_READ: cover property ($fell(sdioDevOen));
endmodule // link_sva

// ---- testbench.sv ----
// Self-checking bench joining both link ends: start-up, detect, wake-up and pin sharing.
`timescale 1ns/10ps
module testbench;
  import link_pkg::*;
  localparam int WAKE = 20;
  localparam int SPIW = 30;
  typedef struct {logic sc1; int minDly;} row_t;
  logic                clk_sys = 1'b0;
  logic                rstn = 1'b0;
  logic                subclass1 = 1'b0;
  logic                adcPowerDown = 1'b1;
  logic                outPowerDown = 1'b1;
  logic [SAMPLE_W-1:0] sampleIn = 14'h0;
  logic                overrangeIn = 1'b0;
  logic                sdioRead = 1'b0;
  logic                linkStart = 1'b0;
  logic                fdFlag, dataReady, cgsPhase, spiReady, linkUp, cgsSearch;
  int                  num_errors = 0;
  int                  comparisons = 0;
  int                  n;
  row_t                rows [2] = '{'{1'b0, SC0_DELAY_MF * FRAMES_PER_MF},
                                    '{1'b1, SC1_DELAY_MF * FRAMES_PER_MF}};
  link_if lnk ();
  adc_link_end #(.WAKE_ADC(WAKE), .WAKE_OUT(WAKE)) u_adc_link_end (.clk_sys(clk_sys),
    .rstn(rstn), .subclass1(subclass1), .adcPowerDown(adcPowerDown),
    .outPowerDown(outPowerDown), .sampleIn(sampleIn), .overrangeIn(overrangeIn),
    .sdioReadActive(sdioRead), .sdioBit(sampleIn[0]), .lnk(lnk.dev),
    .overrange_threshold_flag(fdFlag), .dataReady(dataReady), .code_group_sync_phase(cgsPhase));
  link_rx_end #(.SPI_WAIT(SPIW)) u_link_rx_end (.clk_sys(clk_sys), .rstn(rstn),
    .subclass1(subclass1), .linkStart(linkStart), .sdioRead(sdioRead), .lnk(lnk.host),
    .spiReady(spiReady), .cgsSearch(cgsSearch), .linkUp(linkUp));
  link_sva u_link_sva (.clk_sys(clk_sys), .rstn(rstn), .syncReqN(lnk.syncReqN),
    .sysrefIn(lnk.sysrefIn), .laneWord(lnk.laneWord), .laneValid(lnk.laneValid),
    .laneIsK28(lnk.laneIsK28), .laneIsIla(lnk.laneIsIla), .sdioHost(lnk.sdioHost),
    .sdioHostOen(lnk.sdioHostOen), .sdioDev(lnk.sdioDev), .sdioDevOen(lnk.sdioDevOen));
  // Clock, and a ramp on the sample input so the lane carries changing data.
  always #25 clk_sys = ~clk_sys;
  always @(negedge clk_sys) sampleIn <= sampleIn + 14'h1;
  task automatic stop_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic pick(input int which);
    case (which)
      0: pick = cgsPhase;
      1: pick = linkUp;
      2: pick = dataReady;
      3: pick = spiReady;
      default: pick = fdFlag;
    endcase
  endfunction
  // Counts falling edges until the chosen output is high; a spent bound ends the run.
  task automatic wait_high(input int which, input int limit);
    n = 0;
    while (pick(which) !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > limit) begin
        num_errors++;
        $display("CHECK FAILED wait %0d expected high seen timeout", which);
        stop_test();
      end
    end
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
  endtask
  // Main sequence: serial-port wait first, then the table of link start-ups, then the awkward cases.
  initial begin
    do_reset();
    check("spiReady", 1'b0, spiReady);
    wait_high(3, SPIW + 5);
    check("spi wait", SPIW, n);
    foreach (rows[i]) begin
      // Drop the start request first, or the receiver triggers while the lane still wakes.
      linkStart = 1'b0;
      subclass1 = rows[i].sc1;
      do_reset();
      adcPowerDown = 1'b0;
      outPowerDown = 1'b0;
      wait_high(2, WAKE + 5);
      check("adc wake", WAKE, n);
      repeat (WAKE + 5) @(negedge clk_sys);
      linkStart = 1'b1;
      wait_high(0, 400);
      check("k28 delay", 1'b1, n >= rows[i].minDly);
      check("cgsSearch", 1'b1, cgsSearch);
      check("k28 word", K28_CHAR, lnk.laneWord);
      n = 0;
      while (cgsPhase === 1'b1 && n < 300) begin
        @(negedge clk_sys);
        n++;
      end
      check("k28 length", 1'b1, n >= CGS_MIN_MF * FRAMES_PER_MF);
      check("k28 bound", 1'b1, n < 300);
      check("ila word", ILA_CHAR, lnk.laneWord);
      wait_high(1, 200);
      // The alignment sequence lasts one multiframe; a spent bound fails the length check.
      n = 0;
      while (lnk.laneIsIla === 1'b1 && n < 100) begin
        @(negedge clk_sys);
        n++;
      end
      check("ila length", FRAMES_PER_MF, n);
      check("laneValid", 1'b1, lnk.laneValid);
      check("laneIsK28", 1'b0, lnk.laneIsK28);
    end
    // A one-cycle overrange must come out on the flag after exactly the detect latency.
    overrangeIn = 1'b1;
    @(negedge clk_sys);
    overrangeIn = 1'b0;
    wait_high(4, 20);
    check("detect latency", LAT_FD_CYC - 1, n);
    repeat (2) @(negedge clk_sys);
    check("detect clear", 1'b0, fdFlag);
    // A read hands the data pin to the device, then back.
    sdioRead = 1'b1;
    @(negedge clk_sys);
    check("sdioDevOen gap", 1'b1, lnk.sdioDevOen);
    check("sdioHostOen gap", 1'b1, lnk.sdioHostOen);
    repeat (3) @(negedge clk_sys);
    check("sdioDevOen", 1'b0, lnk.sdioDevOen);
    check("sdioHostOen", 1'b1, lnk.sdioHostOen);
    sdioRead = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("sdioDevOen off", 1'b1, lnk.sdioDevOen);
    check("sdioHostOen back", 1'b0, lnk.sdioHostOen);
    // Power-down while running must silence the lane and withdraw the data.
    outPowerDown = 1'b1;
    adcPowerDown = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("lane off", 1'b0, lnk.laneValid);
    check("data off", 1'b0, dataReady);
    stop_test();
  end
endmodule // testbench
